// File: shared/pio_port_regs.vh
// Register offsets, reset values and width constants for the shared pin port.
// ****************************************************************
// Operation
// [R01] Muxes pick peripheral or port output, enable.
// [R02] Port output never loops into peripheral input.
// [R03] Driving peripheral disables port driver; pin readable.
// [R04] Enabled idle peripheral lets port drive pin.
// [R05] Direction bit one means input.
// [R06] Reset makes every pin an input; a pin that a driving peripheral owns stays driven.
// [R07] Latch register reads latch; writes latch.
// [R08] Level register reads pins; writes latch.
// [R09] Unimplemented bits disabled, read as zero.
// [R10] Input-only shared pins are dedicated port pins.
// [R11] Every port pin is shareable, Schmitt input.
// [R12] Synced pin value feeds readback and peripherals.
// ****************************************************************
`ifndef PIO_PORT_REGS_VH
`define PIO_PORT_REGS_VH

// Byte offsets on the register bus.
`define DIR_OFS         4'h0
`define LATCH_OFS       4'h4
`define LEVEL_OFS       4'h8
`define ADDR_W          4

// Reset values.
`define DIR_RST         16'hFFFF
`define LATCH_RST       16'h0000

// Port width default.
`define PORT_W          16

`endif

// File: design/pin_sync.v
// Two-stage synchroniser for a vector of pin inputs.
`default_nettype none

module pin_sync #(
	parameter W = 16
) (
	// Clock and reset.
	input  wire         clk_i,
	input  wire         sys_rst_i,
	// Asynchronous pins in, synchronised value out.
	input  wire [W-1:0] async_i,
	output wire [W-1:0] sync_o
);

	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// The first stage is read only by the second stage.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule // pin_sync

`default_nettype wire

// File: design/shared_pin_io_port.v
// Shared pin parallel port: direction, latch, level read and pin muxes.
`include "pio_port_regs.vh"
`default_nettype none

module shared_pin_io_port #(
	parameter              W        = `PORT_W,
	// Bits present on this variant; absent bits are disabled.
	parameter [W-1:0]      IMPL_MASK = {W{1'b1}},
	// Bits whose sharing peripheral is input only.
	parameter [W-1:0]      IN_ONLY  = {W{1'b0}}
) (
	// Clock and reset.
	input  wire            clk_i,
	input  wire            sys_rst_i,
	// Avalon-MM slave.
	input  wire [3:0]      avs_address_i,
	input  wire            avs_read_i,
	input  wire            avs_write_i,
	input  wire [31:0]     avs_writedata_i,
	input  wire [3:0]      avs_byteenable_i,
	output wire [31:0]     avs_readdata_o,
	output wire            avs_waitrequest_o,
	// Peripheral side of each pin.
	input  wire [W-1:0]    periph_en_i,
	input  wire [W-1:0]    periph_drive_i,
	input  wire [W-1:0]    periph_out_i,
	output wire [W-1:0]    periph_in_o,
	// Pads.
	input  wire [W-1:0]    pad_i,
	output wire [W-1:0]    pad_o,
	output wire [W-1:0]    pad_oe_o
);

	// ****************************************************************
	// Register file
	// ****************************************************************

	reg  [W-1:0] dir_q;
	reg  [W-1:0] latch_q;
	reg  [31:0]  rdata_q;
	reg          ack_q;
	wire [W-1:0] level_w;
	wire [W-1:0] wmask_w;
	wire         req_w;

	// Byte enables expand to a bit mask over the port width.
	function [W-1:0] be_mask;
		input [3:0] be;
		integer i;
		begin
			be_mask = {W{1'b0}};
			for (i = 0; i < W; i = i + 1)
				be_mask[i] = be[i / 8];
		end
	endfunction

	// Offset decode, used by both read and write paths.
	function is_ofs;
		input [3:0] a;
		input [3:0] ofs;
		begin
			is_ofs = (a == ofs);
		end
	endfunction

	assign wmask_w = be_mask(avs_byteenable_i) & IMPL_MASK;
	assign req_w   = avs_read_i | avs_write_i;

	// One wait cycle per access keeps read data registered.
	assign avs_waitrequest_o = req_w & ~ack_q;
	assign avs_readdata_o    = rdata_q;

	// Direction register; reset makes every pin that no driving peripheral owns an input.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dir_q <= `DIR_RST; // [R06]
		end else if (avs_write_i && !ack_q &&
		             is_ofs(avs_address_i, `DIR_OFS)) begin
			dir_q <= (dir_q & ~wmask_w) |
			         (avs_writedata_i[W-1:0] & wmask_w);
		end
	end

	// Latch takes writes to either the latch or the level offset.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			latch_q <= `LATCH_RST;
		end else if (avs_write_i && !ack_q &&
		             (is_ofs(avs_address_i, `LATCH_OFS) || // [R07]
		              is_ofs(avs_address_i, `LEVEL_OFS))) begin // [R08]
			latch_q <= (latch_q & ~wmask_w) |
			           (avs_writedata_i[W-1:0] & wmask_w);
		end
	end

	// Read mux; unmapped offsets and absent bits read as zero.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_q <= 32'h0000_0000;
			ack_q   <= 1'b0;
		end else begin
			ack_q <= req_w & ~ack_q;
			if (avs_read_i && !ack_q) begin
				rdata_q <= 32'h0000_0000;
				if (is_ofs(avs_address_i, `DIR_OFS))
					rdata_q[W-1:0] <= dir_q & IMPL_MASK; // [R09]
				else if (is_ofs(avs_address_i, `LATCH_OFS))
					rdata_q[W-1:0] <= latch_q & IMPL_MASK; // [R07] [R09]
				else if (is_ofs(avs_address_i, `LEVEL_OFS))
					rdata_q[W-1:0] <= level_w & IMPL_MASK; // [R08] [R09]
			end
		end
	end

	// ****************************************************************
	// Pin logic
	// ****************************************************************

	// Every pin input is synchronised; the Schmitt buffer sits in the pad.
	pin_sync #(
		.W(W)
	) u_sync (
		.clk_i    (clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i  (pad_i), // [R11]
		.sync_o   (level_w)
	);

	// The peripheral's own drive never comes back as the port's output, and
	// the port feeds peripherals only from the pad, so no loop through.
	assign periph_in_o = level_w & IMPL_MASK; // [R12] [R02]

	// Per-pin output mux pair.
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : g_pin
			wire own_w;
			// Peripheral owns the pin only when enabled and driving, and
			// never when its functions on this pin are input only.
			assign own_w = periph_en_i[g] & periph_drive_i[g] &
			               ~IN_ONLY[g]; // [R03] [R04] [R10]
			assign pad_o[g] = IMPL_MASK[g] &
			                  (own_w ? periph_out_i[g]
			                         : latch_q[g]); // [R01]
			assign pad_oe_o[g] = IMPL_MASK[g] &
			                     (own_w ? 1'b1
			                            : ~dir_q[g]); // [R01] [R05]
		end
	endgenerate

endmodule // shared_pin_io_port

`default_nettype wire

// File: verification/pio_props.sv
// Checker for the shared pin port.
`default_nettype none
module pio_props #(
	parameter [15:0] IMPL_MASK = 16'hFFFF,
	parameter [15:0] IN_ONLY   = 16'h0000
) (
	input wire logic        clk_i, sys_rst_i, avs_read_i, avs_write_i,
	input wire logic        avs_waitrequest_o,
	input wire logic [3:0]  avs_address_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic [15:0] periph_en_i, periph_drive_i, periph_out_i,
	input wire logic [15:0] periph_in_o, pad_i, pad_o, pad_oe_o
);
	timeunit 1ns; timeprecision 1ns;
	// Bits a driving peripheral owns.
	wire [15:0] own = periph_en_i & periph_drive_i & ~IN_ONLY & IMPL_MASK;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_own; (pad_oe_o & own) == own
		&& (pad_o & own) == (periph_out_i & own); endproperty
	a_own: assert property (p_own)
		else $error("owner lost pin");
	// The two-flop path follows a pad held stable for three edges once reset has been low for three.
	property p_sync; !$past(sys_rst_i) && !$past(sys_rst_i, 2)
		&& !$past(sys_rst_i, 3) && $stable(pad_i)[*3]
		|-> periph_in_o == (pad_i & IMPL_MASK); endproperty
	a_sync: assert property (p_sync)
		else $error("pin input wrong");
	property p_rst; $fell(sys_rst_i) |-> (pad_oe_o & ~own) == 0; endproperty
	a_rst: assert property (p_rst)
		else $error("pin drives after reset");
	property p_wait; $rose(avs_read_i | avs_write_i)
		|-> avs_waitrequest_o ##1 !avs_waitrequest_o; endproperty
	a_wait: assert property (p_wait)
		else $error("bad wait");
	property p_lvl; $rose(avs_read_i) && avs_address_i == 4'h8
		|-> ##1 avs_readdata_o[15:0] == $past(periph_in_o); endproperty
	a_lvl: assert property (p_lvl)
		else $error("level read wrong");
	property p_hi; avs_read_i && !avs_waitrequest_o
		|-> (avs_readdata_o & ~{16'h0, IMPL_MASK}) == 0; endproperty
	a_hi: assert property (p_hi)
		else $error("absent bit set");
	property p_ionly; !$past(avs_write_i)
		|-> $stable(pad_o & IN_ONLY); endproperty
	a_ionly: assert property (p_ionly)
		else $error("input only pin moved");
	property p_port; !$past(avs_write_i) && $stable(own)
		|-> $stable(pad_oe_o & ~own) && $stable(pad_o & ~own); endproperty
	a_port: assert property (p_port)
		else $error("port pin moved");
endmodule // pio_props
`default_nettype wire

// File: verification/pin_far.sv
// Board side of the pads.
`default_nettype none
module pin_far (
	input wire logic [15:0] o_i, oe_i, ext_i,
	output logic     [15:0] pad_o
);
	timeunit 1ns; timeprecision 1ns;
	// A released pad goes to the board level, never the last driven value.
	assign pad_o = (o_i & oe_i) | (ext_i & ~oe_i);
endmodule // pin_far
`default_nettype wire

// File: verification/tb_shared_pin_io_port.sv
// Testbench for the shared pin port.
`default_nettype none
module tb_shared_pin_io_port;
	timeunit 1ns; timeprecision 1ns;
	logic clk_i = 0, rst = 1, rd = 0, wr = 0;
	logic [3:0] adr = 0;
	logic [31:0] wd = 0;
	logic [15:0] en = 0, drv = 0, pout = 0, ext = 16'hA5C3;
	wire [31:0] rdat;
	wire wt;
	wire [15:0] pin, pad, po, poe;
	int bad_count = 0, compares = 0, cyc = 0;
	shared_pin_io_port #(.IMPL_MASK(16'h7FFF), .IN_ONLY(16'h0001)) u_dut (
		.clk_i(clk_i), .sys_rst_i(rst), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wt), .periph_en_i(en),
		.periph_drive_i(drv), .periph_out_i(pout), .periph_in_o(pin),
		.pad_i(pad), .pad_o(po), .pad_oe_o(poe));
	pin_far u_far (.o_i(po), .oe_i(poe), .ext_i(ext), .pad_o(pad));
	initial forever #50 clk_i = ~clk_i;
	always @(posedge clk_i) if (++cyc == 3000) begin
		bad_count++;
		wrap_up();
	end
	task automatic chk(input logic [31:0] g, e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: %h not %h", $time, g, e);
		end
	endtask
	// Bus cycle held until wait is seen low at a falling edge.
	task automatic acc(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		logic ok;
		adr <= a; wd <= d; wr <= w; rd <= !w;
		do begin
			@(negedge clk_i) ok = (wt === 1'b0);
			@(posedge clk_i);
		end while (!ok);
		rd <= 0; wr <= 0;
		@(posedge clk_i);
	endtask
	task automatic wrap_up();
		$display("mismatches %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst <= 0;
		@(posedge clk_i);
		acc(0, 4'h0, 0); chk(rdat, 32'h7FFF);
		acc(0, 4'h4, 0); chk(rdat, 0);
		acc(1, 4'h0, 0);
		acc(1, 4'h4, 32'hF00F);
		acc(0, 4'h4, 0); chk(rdat, 32'h700F);
		chk(poe & 16'h7FFF, 16'h7FFF);
		acc(0, 4'h8, 0); chk(rdat, 32'h700F);
		acc(1, 4'h8, 32'h00F0);
		acc(0, 4'h4, 0); chk(rdat, 32'h00F0);
		en <= 16'h00F1; drv <= 16'h0011; pout <= 16'h0001;
		repeat (3) @(posedge clk_i);
		chk(po & 16'h7FFF, 16'h00E0);
		acc(0, 4'h8, 0); chk(rdat, 32'h00E0);
		chk(pin, 32'h00E0);
		en <= 0;
		acc(1, 4'h0, 32'hFFFF);
		repeat (3) @(posedge clk_i);
		acc(0, 4'h8, 0); chk(rdat, 32'h25C3);
		chk(pin, 32'h25C3);
		acc(0, 4'hC, 0); chk(rdat, 0);
		wrap_up();
	end
endmodule // tb_shared_pin_io_port
bind shared_pin_io_port pio_props #(.IMPL_MASK(IMPL_MASK),
	.IN_ONLY(IN_ONLY)) u_props (.*);
`default_nettype wire
